/* File: hw/peak_telemetry_config_regs.sv */
// Purpose: Peak-hold telemetry and user identification registers
// Assumes: Command decode from the bus engine, same clock, one-cycle strobes
// Notes: Read data is registered, valid one cycle after the read strobe
//
// Contract
// R1 - Command A5h returns the highest output voltage sample, 16 bits.
// R2 - Command A6h returns the highest output current sample, 16 bits.
// R3 - Command AFh returns the highest die temperature sample, 16 bits.
// R4 - Peaks clear on read and hold the maximum since the previous read.
// R5 - Voltage and current encoding chosen by format bit 9: linear or direct.
// R6 - Linear: signed exponent in bits 15:11, signed mantissa in bits 10:0.
// R7 - Direct voltage: bits 15:11 zero, 31.25 mV per count below.
// R8 - Direct current: bits 15:14 zero, 62.5 mA per count below.
// R9 - Temperature bits 15:8 ignore writes and read zero.
// R10 - Temperature peak unsigned in bits 7:0, one degree per count.
// R11 - Command C0h read-write part-number code, reads last written value.
// R12 - Command C1h read-write configuration revision, reads last written.
// R13 - First sample after clear loads; sample colliding with read is kept.
`timescale 1ns/1ps
`default_nettype none
module peak_telemetry_config_regs
  import peak_regs_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic LINEAR_MODE,
  input wire peak_regs_pkg::reg_req_t REQ,
  input wire peak_regs_pkg::sample_t SAMPLE,
  output logic [15:0] RDATA,
  output logic RVALID
);
  import peak_regs_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Linear words compare by real value; direct words are plain unsigned.
  function automatic logic lin_greater(input logic [15:0] a,
                                       input logic [15:0] b);
    logic signed [47:0] va;
    logic signed [47:0] vb;
    va = 48'(signed'(a[LIN_MANT_W-1:0])) <<< (5'(a[15:LIN_MANT_W]) + 5'd16);
    vb = 48'(signed'(b[LIN_MANT_W-1:0])) <<< (5'(b[15:LIN_MANT_W]) + 5'd16);
    if (a[15])
      va = 48'(signed'(a[LIN_MANT_W-1:0])) <<<
           (5'd16 - 5'(-signed'(a[15:LIN_MANT_W])));
    if (b[15])
      vb = 48'(signed'(b[LIN_MANT_W-1:0])) <<<
           (5'd16 - 5'(-signed'(b[15:LIN_MANT_W])));
    return va > vb;
  endfunction

  function automatic logic is_greater(input logic lin,
                                      input logic [15:0] a,
                                      input logic [15:0] b);
    return lin ? lin_greater(a, b) : (a > b);
  endfunction

  // Direct words force the bits that direct format reads as zero
  function automatic logic [15:0] direct_vout(input logic [15:0] w);
    return {5'h00, w[VOUT_DIRECT_W-1:0]};
  endfunction

  function automatic logic [15:0] direct_iout(input logic [15:0] w);
    return {2'h0, w[IOUT_DIRECT_W-1:0]};
  endfunction

  // ----------------------------------------------------------------
  // Sample formatting
  // ----------------------------------------------------------------
  logic [15:0] vout_fmt;
  logic [15:0] iout_fmt;
  logic [15:0] temp_fmt;
  always_comb begin
    vout_fmt = SAMPLE.vout; // R6
    iout_fmt = SAMPLE.iout; // R6
    if (!LINEAR_MODE) begin // R5
      vout_fmt = direct_vout(SAMPLE.vout); // R7
      iout_fmt = direct_iout(SAMPLE.iout); // R8
    end
    temp_fmt = {8'h00, SAMPLE.temp}; // R9 R10
  end

  wire logic rd_vout = REQ.rd && REQ.cmd == CMD_VOUT_PEAK;
  wire logic rd_iout = REQ.rd && REQ.cmd == CMD_IOUT_PEAK;
  wire logic rd_temp = REQ.rd && REQ.cmd == CMD_TEMP_PEAK;

  // ----------------------------------------------------------------
  // Peak trackers
  // ----------------------------------------------------------------
  // A colliding sample starts the next interval, so it is never lost.
  logic [15:0] vout_peak;
  logic [15:0] iout_peak;
  logic [15:0] temp_peak;
  peak_state_t vout_st;
  peak_state_t iout_st;
  peak_state_t temp_st;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      vout_peak <= WORD_ZERO;
      vout_st <= ST_EMPTY;
    end else if (CE) begin
      if (rd_vout) begin // R4
        vout_peak <= SAMPLE.vout_vld ? vout_fmt : WORD_ZERO; // R13
        vout_st <= SAMPLE.vout_vld ? ST_HELD : ST_EMPTY; // R13
      end else if (SAMPLE.vout_vld) begin
        if (vout_st == ST_EMPTY ||
            is_greater(LINEAR_MODE, vout_fmt, vout_peak)) begin // R1 R13
          vout_peak <= vout_fmt;
        end
        vout_st <= ST_HELD;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      iout_peak <= WORD_ZERO;
      iout_st <= ST_EMPTY;
    end else if (CE) begin
      if (rd_iout) begin // R4
        iout_peak <= SAMPLE.iout_vld ? iout_fmt : WORD_ZERO; // R13
        iout_st <= SAMPLE.iout_vld ? ST_HELD : ST_EMPTY; // R13
      end else if (SAMPLE.iout_vld) begin
        if (iout_st == ST_EMPTY ||
            is_greater(LINEAR_MODE, iout_fmt, iout_peak)) begin // R2 R13
          iout_peak <= iout_fmt;
        end
        iout_st <= ST_HELD;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      temp_peak <= WORD_ZERO;
      temp_st <= ST_EMPTY;
    end else if (CE) begin
      if (rd_temp) begin // R4
        temp_peak <= SAMPLE.temp_vld ? temp_fmt : WORD_ZERO; // R13
        temp_st <= SAMPLE.temp_vld ? ST_HELD : ST_EMPTY; // R13
      end else if (SAMPLE.temp_vld) begin
        if (temp_st == ST_EMPTY || temp_fmt > temp_peak) begin // R3 R10
          temp_peak <= temp_fmt;
        end
        temp_st <= ST_HELD;
      end
    end
  end

  // ----------------------------------------------------------------
  // User identification words
  // ----------------------------------------------------------------
  logic [15:0] part_code;
  logic [15:0] cfg_rev;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      part_code <= WORD_ZERO;
      cfg_rev <= WORD_ZERO;
    end else if (CE && REQ.wr) begin
      if (REQ.cmd == CMD_PART_CODE)
        part_code <= REQ.wdata; // R11
      if (REQ.cmd == CMD_CFG_REV)
        cfg_rev <= REQ.wdata; // R12
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Writes to the peak commands are ignored; unmapped reads return zero.
  // A word kept across a mode change still reads zero in direct-only bits
  logic [15:0] next_rdata;
  always_comb begin
    case (REQ.cmd)
      CMD_VOUT_PEAK: begin
        next_rdata = vout_peak; // R1
        if (!LINEAR_MODE)
          next_rdata = direct_vout(vout_peak); // R7
      end
      CMD_IOUT_PEAK: begin
        next_rdata = iout_peak; // R2
        if (!LINEAR_MODE)
          next_rdata = direct_iout(iout_peak); // R8
      end
      CMD_TEMP_PEAK: next_rdata = {8'h00, temp_peak[TEMP_W-1:0]}; // R9
      CMD_PART_CODE: next_rdata = part_code; // R11
      CMD_CFG_REV: next_rdata = cfg_rev; // R12
      default: next_rdata = WORD_ZERO;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= WORD_ZERO;
      RVALID <= 1'b0;
    end else if (CE) begin
      RVALID <= REQ.rd;
      if (REQ.rd)
        RDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_temp_upper_zero: assert property ( // R9
    $past(CE && REQ.rd && REQ.cmd == CMD_TEMP_PEAK)
    |-> RDATA[15:8] == 8'h00)
    else $error("temperature upper byte not zero");
  a_vout_direct_zero: assert property ( // R7
    CE && rd_vout && !LINEAR_MODE |=> RDATA[15:11] == 5'h00)
    else $error("direct voltage exponent bits not zero");
  a_iout_direct_zero: assert property ( // R8
    CE && rd_iout && !LINEAR_MODE |=> RDATA[15:14] == 2'h0)
    else $error("direct current top bits not zero");
  a_read_clears_peak: assert property ( // R4
    CE && rd_vout && !SAMPLE.vout_vld |=> vout_peak == WORD_ZERO
    && vout_st == ST_EMPTY)
    else $error("voltage peak not cleared by read");
  a_collide_kept: assert property ( // R13
    CE && rd_iout && SAMPLE.iout_vld |=> iout_peak == $past(iout_fmt)
    && iout_st == ST_HELD)
    else $error("colliding current sample lost");
  a_temp_holds_max: assert property ( // R3
    CE && !rd_temp && SAMPLE.temp_vld && temp_st == ST_HELD
    |=> temp_peak >= $past(temp_peak) && temp_peak >= $past(temp_fmt))
    else $error("temperature peak dropped");
  a_first_loads: assert property ( // R13
    CE && !rd_vout && SAMPLE.vout_vld && vout_st == ST_EMPTY
    |=> vout_peak == $past(vout_fmt))
    else $error("first sample not loaded");
  a_part_code_rw: assert property ( // R11
    CE && REQ.wr && REQ.cmd == CMD_PART_CODE
    |=> part_code == $past(REQ.wdata))
    else $error("part code not stored");
  a_cfg_rev_rw: assert property ( // R12
    CE && REQ.wr && REQ.cmd == CMD_CFG_REV |=> cfg_rev == $past(REQ.wdata))
    else $error("config revision not stored");
  a_rvalid_follows: assert property ( // R1
    CE && REQ.rd |=> RVALID)
    else $error("read not answered");
  a_ce_freezes_state: assert property ( // R4
    !CE |=> $stable(vout_peak) && $stable(iout_peak) && $stable(temp_peak)
    && $stable(RDATA) && $stable(RVALID))
    else $error("state changed while clock enable low");

  c_vout_read: cover property (CE && rd_vout && vout_st == ST_HELD);
  c_collide: cover property (CE && rd_temp && SAMPLE.temp_vld);
  c_linear_iout: cover property (CE && LINEAR_MODE && SAMPLE.iout_vld
    && iout_st == ST_HELD);
  c_id_write: cover property (CE && REQ.wr && REQ.cmd == CMD_CFG_REV);
  c_frozen_read: cover property (!CE && REQ.rd);
endmodule
`default_nettype wire

/* File: hw/peak_regs_pkg.sv */
// Purpose: Constants and carriers for the peak telemetry register bank
// Assumes: 8-bit command codes, 16-bit register words
// Notes: Shared by design and bench
package peak_regs_pkg;
  localparam logic [7:0] CMD_VOUT_PEAK = 8'ha5;
  localparam logic [7:0] CMD_IOUT_PEAK = 8'ha6;
  localparam logic [7:0] CMD_TEMP_PEAK = 8'haf;
  localparam logic [7:0] CMD_PART_CODE = 8'hc0;
  localparam logic [7:0] CMD_CFG_REV = 8'hc1;
  localparam int CFG_FORMAT_BIT = 9;
  localparam int LIN_MANT_W = 11;
  localparam int VOUT_DIRECT_W = 11;
  localparam int IOUT_DIRECT_W = 14;
  localparam int TEMP_W = 8;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam real VOUT_LSB_MV = 31.25;
  localparam real IOUT_LSB_MA = 62.5;
  localparam real TEMP_LSB_C = 1.0;

  // One command on the register port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } reg_req_t;

  // Samples from the front end, one strobe per quantity
  typedef struct packed {
    logic vout_vld;
    logic [15:0] vout;
    logic iout_vld;
    logic [15:0] iout;
    logic temp_vld;
    logic [7:0] temp;
  } sample_t;

  typedef enum logic [1:0] {
    ST_EMPTY = 2'b00,
    ST_HELD = 2'b01
  } peak_state_t;
endpackage

/* File: verif/peak_host_model.sv */
// Purpose: Host side model issuing register commands to the peak bank
// Assumes: One command at a time, taken on the edge after it is set
// Notes: No ready exists, so a command stands exactly one edge
`timescale 1ns/1ps
`default_nettype none
module peak_host_model (
  input wire logic CLK,
  output var peak_regs_pkg::reg_req_t REQ,
  input wire logic [15:0] RDATA,
  input wire logic RVALID
);
  import peak_regs_pkg::*;

  initial REQ = '0;

  // ------------------------------------------------------------
  // Command cycle
  // ------------------------------------------------------------
  // Data is taken at the edge where the answer is sampled high
  task automatic access(input logic rd, input logic [7:0] cmd,
    input logic [15:0] wd, output logic [15:0] rdat, output logic vld);
    @(posedge CLK);
    REQ <= '{rd: rd, wr: !rd, cmd: cmd, wdata: wd};
    @(posedge CLK);
    REQ <= '0;
    @(posedge CLK);
    rdat = RDATA;
    vld = RVALID;
  endtask
endmodule
`default_nettype wire

/* File: verif/test_peak_telemetry_config_regs.sv */
// Purpose: Self-checking bench for the peak telemetry register bank
// Assumes: Samples driven by the bench in place of the front end
// Notes: CE is lowered once to check that the voltage peak and the read port freeze
`timescale 1ns/1ps
`default_nettype none
module test_peak_telemetry_config_regs;
  import peak_regs_pkg::*;
  logic clk, rst_b, ce, linear_mode, rvalid, vld;
  reg_req_t req;
  sample_t sample;
  logic [15:0] rdata, got;
  int mismatches, checks_done;
  typedef struct {logic lin; logic [7:0] cmd; logic [15:0] a, b, exp;} row_t;
  // Linear rows pick pairs whose raw order differs from their value order
  row_t rows[7] = '{
    '{1'b0, CMD_VOUT_PEAK, 16'h0123, 16'h0456, 16'h0456},
    '{1'b0, CMD_VOUT_PEAK, 16'hffff, 16'h0001, 16'h07ff},
    '{1'b0, CMD_IOUT_PEAK, 16'hffff, 16'h0002, 16'h3fff},
    '{1'b0, CMD_TEMP_PEAK, 16'h0080, 16'h007f, 16'h0080},
    '{1'b1, CMD_VOUT_PEAK, 16'h0007, 16'h0803, 16'h0007},
    '{1'b1, CMD_IOUT_PEAK, 16'h07ff, 16'h0001, 16'h0001},
    '{1'b1, CMD_IOUT_PEAK, 16'hf804, 16'h0003, 16'h0003}
  };

  peak_telemetry_config_regs dut (.CLK(clk), .RST_B(rst_b), .CE(ce),
    .LINEAR_MODE(linear_mode), .REQ(req), .SAMPLE(sample), .RDATA(rdata),
    .RVALID(rvalid));
  peak_host_model host (.CLK(clk), .REQ(req), .RDATA(rdata),
    .RVALID(rvalid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle data is inverted so a design ignoring the strobe is caught
  task automatic put(input logic [7:0] cmd, input logic [15:0] v);
    @(posedge clk);
    sample <= '{cmd == CMD_VOUT_PEAK, v, cmd == CMD_IOUT_PEAK, v,
      cmd == CMD_TEMP_PEAK, v[7:0]};
    @(posedge clk);
    sample <= '{1'b0, ~v, 1'b0, ~v, 1'b0, ~v[7:0]};
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    host.access(1'b1, cmd, 16'h0000, got, vld);
    check({15'h0000, vld}, 16'h0001);
    check(got, exp);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
    host.access(1'b0, cmd, v, got, vld);
    check({15'h0000, vld}, 16'h0000);
  endtask

  // A smaller sample colliding with the read opens the next interval
  task automatic collide(input logic [7:0] cmd);
    put(cmd, 16'h0040);
    fork
      rd(cmd, 16'h0040);
      put(cmd, 16'h0010);
    join
    rd(cmd, 16'h0010);
  endtask

  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    linear_mode = 1'b0;
    sample = '0;
    repeat (20) @(posedge clk);
    check(rdata, 16'h0000);
    check({15'h0000, rvalid}, 16'h0000);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      linear_mode <= rows[i].lin;
      put(rows[i].cmd, rows[i].a);
      put(rows[i].cmd, rows[i].b);
      rd(rows[i].cmd, rows[i].exp);
      rd(rows[i].cmd, 16'h0000);
    end
    linear_mode <= 1'b0;
    wr(CMD_PART_CODE, 16'h1234);
    wr(CMD_CFG_REV, 16'habcd);
    rd(CMD_PART_CODE, 16'h1234);
    rd(CMD_CFG_REV, 16'habcd);
    wr(CMD_TEMP_PEAK, 16'hff55);
    rd(CMD_TEMP_PEAK, 16'h0000);
    wr(CMD_VOUT_PEAK, 16'h0111);
    rd(CMD_VOUT_PEAK, 16'h0000);
    rd(8'h00, 16'h0000);
    collide(CMD_TEMP_PEAK);
    collide(CMD_IOUT_PEAK);
    // Frozen clock enable: no sample lands, no read is taken or cleared
    put(CMD_VOUT_PEAK, 16'h0100);
    ce <= 1'b0;
    put(CMD_VOUT_PEAK, 16'h0200);
    host.access(1'b1, CMD_VOUT_PEAK, 16'h0000, got, vld);
    check({15'h0000, vld}, 16'h0000);
    check(got, 16'h0010);
    ce <= 1'b1;
    rd(CMD_VOUT_PEAK, 16'h0100);
    // Reset in mid-run clears the read port and the part code
    wr(CMD_PART_CODE, 16'h5a5a);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check(rdata, 16'h0000);
    check({15'h0000, rvalid}, 16'h0000);
    rst_b <= 1'b1;
    rd(CMD_PART_CODE, 16'h0000);
    complete_run;
  end
endmodule
`default_nettype wire
